// file: core/swd_pkg.sv
package swd_pkg;

   // Time base: one tick per millisecond at a 5 ns clock
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned TICK_PERIOD_MS = 1;
   localparam int unsigned TICK_CYCLES_DFLT = (TICK_PERIOD_MS * 1000000000) / CLK_PERIOD_PS;

   localparam int unsigned CNT_W = 21;
   localparam logic [CNT_W-1:0] CNT_ZERO = 21'h000000;
   localparam logic [CNT_W-1:0] CNT_ONE  = 21'h000001;

   // Timeouts in milliseconds
   localparam logic [CNT_W-1:0] MS_1S   = 21'h0003E8;
   localparam logic [CNT_W-1:0] MS_2S   = 21'h0007D0;
   localparam logic [CNT_W-1:0] MS_5S   = 21'h001388;
   localparam logic [CNT_W-1:0] MS_10S  = 21'h002710;
   localparam logic [CNT_W-1:0] MS_30S  = 21'h007530;
   localparam logic [CNT_W-1:0] MS_1M   = 21'h00EA60;
   localparam logic [CNT_W-1:0] MS_2M   = 21'h01D4C0;
   localparam logic [CNT_W-1:0] MS_5M   = 21'h0493E0;
   localparam logic [CNT_W-1:0] MS_10M  = 21'h0927C0;
   localparam logic [CNT_W-1:0] MS_30M  = 21'h1B7740;

   // Boot-time watchdog select: 0 off, 1 30s, 2 1m, 3 2m, 4 5m, 5 10m, 6 30m
   localparam logic [2:0] POST_OFF = 3'h0;
   // Activation delay select: 0 off, 1 10s, 2 30s, 3 1m, 4 2m, 5 5m, 6 10m, 7 30m
   localparam logic [2:0] DLY_OFF  = 3'h0;

   // Runtime mode
   localparam logic [1:0] MODE_OFF    = 2'h0;
   localparam logic [1:0] MODE_ONCE   = 2'h1;
   localparam logic [1:0] MODE_SINGLE = 2'h2;
   localparam logic [1:0] MODE_REPEAT = 2'h3;

   // Stage action
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_ACPI = 2'h1;
   localparam logic [1:0] ACT_RST  = 2'h2;
   localparam logic [1:0] ACT_PWR  = 2'h3;

   localparam logic [1:0] STG_1 = 2'h1;
   localparam logic [1:0] STG_2 = 2'h2;
   localparam logic [1:0] STG_3 = 2'h3;

   typedef enum logic [1:0] {
      RT_IDLE  = 2'h0,
      RT_DELAY = 2'h1,
      RT_RUN   = 2'h3,
      RT_OFF   = 2'h2
   } swd_rt_type;

   typedef struct packed {
      swd_rt_type       rt;
      logic [1:0]       stage;
      logic [CNT_W-1:0] rt_cnt;
      logic [CNT_W-1:0] post_cnt;
      logic             post_fired;
      logic [1:0]       mode;
      logic [2:0]       dly;
      logic [1:0]       ev1;
      logic [1:0]       ev2;
      logic [1:0]       ev3;
      logic [3:0]       to1;
      logic [3:0]       to2;
      logic [3:0]       to3;
      logic             acpi_restart;
      logic             post_active;
      logic             sys_reset;
      logic             pwr_button;
      logic             acpi_overtemp;
      logic             acpi_fatal;
   } swd_state_type;

   function automatic logic [CNT_W-1:0] swd_stage_ms(input logic [3:0] sel);
      case (sel)
         4'h0:    swd_stage_ms = MS_1S;
         4'h1:    swd_stage_ms = MS_2S;
         4'h2:    swd_stage_ms = MS_5S;
         4'h3:    swd_stage_ms = MS_10S;
         4'h4:    swd_stage_ms = MS_30S;
         4'h5:    swd_stage_ms = MS_1M;
         4'h6:    swd_stage_ms = MS_2M;
         4'h7:    swd_stage_ms = MS_5M;
         4'h8:    swd_stage_ms = MS_10M;
         default: swd_stage_ms = MS_30M;
      endcase
   endfunction

   function automatic logic [CNT_W-1:0] swd_post_ms(input logic [2:0] sel);
      case (sel)
         3'h1:    swd_post_ms = MS_30S;
         3'h2:    swd_post_ms = MS_1M;
         3'h3:    swd_post_ms = MS_2M;
         3'h4:    swd_post_ms = MS_5M;
         3'h5:    swd_post_ms = MS_10M;
         default: swd_post_ms = MS_30M;
      endcase
   endfunction

   function automatic logic [CNT_W-1:0] swd_delay_ms(input logic [2:0] sel);
      case (sel)
         3'h1:    swd_delay_ms = MS_10S;
         3'h2:    swd_delay_ms = MS_30S;
         3'h3:    swd_delay_ms = MS_1M;
         3'h4:    swd_delay_ms = MS_2M;
         3'h5:    swd_delay_ms = MS_5M;
         3'h6:    swd_delay_ms = MS_10M;
         default: swd_delay_ms = MS_30M;
      endcase
   endfunction

endpackage

// file: core/swd_tick.sv
`timescale 1ns/1ps
module swd_tick
   import swd_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
   input  wire logic i_core_clk,
   input  wire logic i_arst_n,
   input  wire logic i_ce,
   output logic      o_tick
);
   localparam int unsigned TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
   localparam logic [TW-1:0] T_LAST = TW'(TICK_CYCLES - 1);
   localparam logic [TW-1:0] T_ZERO = '0;
   localparam logic [TW-1:0] T_ONE  = TW'(1);

   typedef struct packed {
      logic [TW-1:0] cnt;
      logic          tick;
   } swd_tick_type;

   swd_tick_type st;
   swd_tick_type next_st;

   if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("swd_tick: TICK_CYCLES must be at least 2");
   end

   // Millisecond prescaler
   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (st.cnt == T_LAST) begin
         next_st.cnt  = T_ZERO;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt + T_ONE;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st <= '0;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   assign o_tick = st.tick;

endmodule // swd_tick

// file: core/swd_watchdog.sv
// Functional notes
// - Boot watchdog timeout off, 30s, 1, 2, 5, 10, 30 min; off default.
// - Boot watchdog counts only during self test; expiry forces system reset.
// - Optionally halt boot watchdog while boot selection menu shows.
// - Optionally halt boot watchdog while waiting for setup password.
// - One-time trigger mode disables runtime watchdog after first trigger past the activation delay.
// - Single event mode runs each stage ahead of any disabled stage once, then disables.
// - Repeated event mode reruns last stage ahead of any disabled stage until system reset.
// - Runtime watchdog initialised only just before OS boot; default off.
// - Optional activation delay off, 10s, 30s, 1, 2, 5, 10, 30 min.
// - Stage one expiry raises ACPI, reset or power button; never disabled.
// - Stages two and three choose disabled, ACPI, reset or power button.
// - Stage one timeout 1, 2, 5, 10, 30 s or 1, 2, 5, 10, 30 min.
// - Stage two and three timeouts chosen independently from same set.
// - ACPI event selects orderly shutdown or orderly restart.
// - ACPI shutdown is issued as an over-temperature notification.
// - ACPI restart is issued as an ACPI fatal error report.
`timescale 1ns/1ps
module swd_watchdog
   import swd_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
   input  wire logic       i_core_clk,
   input  wire logic       i_arst_n,
   input  wire logic       i_ce,
   input  wire logic [2:0] i_post_sel,
   input  wire logic       i_stop_user_en,
   input  wire logic       i_stop_pwd_en,
   input  wire logic       i_post_running,
   input  wire logic       i_boot_menu_shown,
   input  wire logic       i_pwd_wait,
   input  wire logic [1:0] i_rt_mode,
   input  wire logic [2:0] i_rt_delay_sel,
   input  wire logic [1:0] i_ev1_sel,
   input  wire logic [1:0] i_ev2_sel,
   input  wire logic [1:0] i_ev3_sel,
   input  wire logic [3:0] i_to1_sel,
   input  wire logic [3:0] i_to2_sel,
   input  wire logic [3:0] i_to3_sel,
   input  wire logic       i_acpi_restart,
   input  wire logic       i_os_boot_start,
   input  wire logic       i_trigger,
   output logic            o_sys_reset,
   output logic            o_pwr_button,
   output logic            o_acpi_overtemp,
   output logic            o_acpi_fatal,
   output logic            o_post_active,
   output logic [1:0]      o_rt_state,
   output logic [1:0]      o_rt_stage
);

   swd_state_type    st;
   swd_state_type    next_st;
   logic             tick;
   logic             post_halt;
   logic             post_count;
   logic             post_expire;
   logic [1:0]       cur_act;
   logic [CNT_W-1:0] cur_ms;
   logic             rt_expire;
   logic             dly_expire;
   logic [1:0]       nxt_act;
   logic             is_last;

   if (CNT_W < 21) begin : g_bad_width
      $error("swd_watchdog: counter too narrow for 30 min");
   end

   swd_tick #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .i_core_clk (i_core_clk),
      .i_arst_n   (i_arst_n),
      .i_ce       (i_ce),
      .o_tick     (tick)
   );

   function automatic logic [1:0] stage_act(input swd_state_type s, input logic [1:0] stg);
      case (stg)
         STG_1:   stage_act = (s.ev1 == ACT_NONE) ? ACT_ACPI : s.ev1;
         STG_2:   stage_act = s.ev2;
         STG_3:   stage_act = s.ev3;
         default: stage_act = ACT_NONE;
      endcase
   endfunction

   function automatic logic [3:0] stage_to(input swd_state_type s, input logic [1:0] stg);
      case (stg)
         STG_2:   stage_to = s.to2;
         STG_3:   stage_to = s.to3;
         default: stage_to = s.to1;
      endcase
   endfunction

   // Boot-time watchdog conditions
   assign post_halt   = (i_stop_user_en & i_boot_menu_shown)
                      | (i_stop_pwd_en & i_pwd_wait);
   assign post_count  = i_post_running && (i_post_sel != POST_OFF)
                      && !post_halt && !st.post_fired;
   assign post_expire = post_count && tick
                      && (st.post_cnt == swd_post_ms(i_post_sel) - CNT_ONE);

   // Runtime stage conditions
   assign cur_act    = stage_act(st, st.stage);
   assign cur_ms     = swd_stage_ms(stage_to(st, st.stage));
   assign rt_expire  = (st.rt == RT_RUN) && tick && (st.rt_cnt == cur_ms - CNT_ONE);
   assign dly_expire = (st.rt == RT_DELAY) && tick
                     && (st.rt_cnt == swd_delay_ms(st.dly) - CNT_ONE);
   assign nxt_act    = (st.stage == STG_3) ? ACT_NONE : stage_act(st, st.stage + STG_1);
   assign is_last    = (nxt_act == ACT_NONE);

   always_comb begin
      next_st = st;
      next_st.sys_reset     = 1'b0;
      next_st.pwr_button    = 1'b0;
      next_st.acpi_overtemp = 1'b0;
      next_st.acpi_fatal    = 1'b0;

      // Boot-time watchdog
      if (!i_post_running) begin
         next_st.post_cnt   = CNT_ZERO;
         next_st.post_fired = 1'b0;
      end else if (post_expire) begin
         next_st.post_fired = 1'b1;
         next_st.sys_reset  = 1'b1;
      end else if (post_count && tick) begin
         next_st.post_cnt = st.post_cnt + CNT_ONE;
      end
      next_st.post_active = post_count;

      // Runtime watchdog
      case (st.rt)
         RT_IDLE: begin
            if (i_os_boot_start) begin
               next_st.mode         = i_rt_mode;
               next_st.dly          = i_rt_delay_sel;
               next_st.ev1          = i_ev1_sel;
               next_st.ev2          = i_ev2_sel;
               next_st.ev3          = i_ev3_sel;
               next_st.to1          = i_to1_sel;
               next_st.to2          = i_to2_sel;
               next_st.to3          = i_to3_sel;
               next_st.acpi_restart = i_acpi_restart;
               next_st.rt_cnt       = CNT_ZERO;
               next_st.stage        = STG_1;
               if (i_rt_mode == MODE_OFF) begin
                  next_st.rt = RT_OFF;
               end else if (i_rt_delay_sel == DLY_OFF) begin
                  next_st.rt = RT_RUN;
               end else begin
                  next_st.rt = RT_DELAY;
               end
            end
         end
         RT_DELAY: begin
            if (dly_expire) begin
               next_st.rt     = RT_RUN;
               next_st.rt_cnt = CNT_ZERO;
            end else if (tick) begin
               next_st.rt_cnt = st.rt_cnt + CNT_ONE;
            end
         end
         RT_RUN: begin
            if (i_trigger && st.mode == MODE_ONCE) begin
               next_st.rt = RT_OFF;
            end else if (i_trigger) begin
               next_st.stage  = STG_1;
               next_st.rt_cnt = CNT_ZERO;
            end else if (rt_expire) begin
               case (cur_act)
                  ACT_ACPI: begin
                     next_st.acpi_overtemp = !st.acpi_restart;
                     next_st.acpi_fatal    = st.acpi_restart;
                  end
                  ACT_RST:  next_st.sys_reset  = 1'b1;
                  ACT_PWR:  next_st.pwr_button = 1'b1;
                  default:  next_st.sys_reset  = 1'b0;
               endcase
               next_st.rt_cnt = CNT_ZERO;
               if (!is_last) begin
                  next_st.stage = st.stage + STG_1;
               end else if (st.mode != MODE_REPEAT) begin
                  next_st.rt = RT_OFF;
               end
            end else if (tick) begin
               next_st.rt_cnt = st.rt_cnt + CNT_ONE;
            end
         end
         RT_OFF: begin
            next_st.rt = RT_OFF;
         end
         default: begin
            next_st.rt = RT_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st <= '0;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   assign o_sys_reset     = st.sys_reset;
   assign o_pwr_button    = st.pwr_button;
   assign o_acpi_overtemp = st.acpi_overtemp;
   assign o_acpi_fatal    = st.acpi_fatal;
   assign o_post_active   = st.post_active;
   assign o_rt_state      = st.rt;
   assign o_rt_stage      = st.stage;

   // Checks
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_arst_n);

   a_post_off_idle: assert property (
      (i_ce && i_post_sel == POST_OFF) |=> !o_post_active)
      else $error("boot watchdog active while off");
   a_post_clear: assert property (
      (i_ce && !i_post_running) |=> (st.post_cnt == CNT_ZERO) && !o_post_active)
      else $error("boot watchdog not cleared outside self test");
   a_post_reset: assert property (
      (i_ce && post_expire) |=> o_sys_reset ##1 (!o_sys_reset || !$past(i_ce)))
      else $error("boot watchdog expiry did not pulse reset");
   a_menu_halt: assert property (
      (i_ce && i_post_running && i_stop_user_en && i_boot_menu_shown)
      |=> $stable(st.post_cnt) && !o_post_active)
      else $error("boot watchdog counted during menu");
   a_pwd_halt: assert property (
      (i_ce && i_post_running && i_stop_pwd_en && i_pwd_wait)
      |=> $stable(st.post_cnt) && !o_post_active)
      else $error("boot watchdog counted during password wait");
   a_once_trig_off: assert property (
      (i_ce && st.rt == RT_RUN && st.mode == MODE_ONCE && i_trigger) |=> st.rt == RT_OFF)
      else $error("one-time trigger did not disable");
   a_single_end: assert property (
      (i_ce && rt_expire && !i_trigger && is_last && st.mode == MODE_SINGLE)
      |=> st.rt == RT_OFF)
      else $error("single event did not end");
   a_repeat_stay: assert property (
      (i_ce && rt_expire && !i_trigger && is_last && st.mode == MODE_REPEAT)
      |=> st.rt == RT_RUN && st.stage == $past(st.stage) && st.rt_cnt == CNT_ZERO)
      else $error("repeated event left last stage");
   a_init_gate: assert property (
      (st.rt == RT_IDLE && !(i_ce && i_os_boot_start)) |=> st.rt == RT_IDLE)
      else $error("runtime watchdog started without OS boot");
   a_stage_fire: assert property (
      (i_ce && rt_expire && !i_trigger && st.stage == STG_1)
      |=> (o_sys_reset || o_pwr_button || o_acpi_overtemp || o_acpi_fatal))
      else $error("stage one expiry raised no action");
   a_acpi_kind: assert property (
      (o_acpi_overtemp || o_acpi_fatal) |-> (o_acpi_fatal == st.acpi_restart)
      && !(o_acpi_overtemp && o_acpi_fatal))
      else $error("wrong ACPI event kind");
   a_trig_reload: assert property (
      (i_ce && st.rt == RT_RUN && st.mode != MODE_ONCE && i_trigger)
      |=> st.stage == STG_1 && st.rt_cnt == CNT_ZERO)
      else $error("trigger did not reload stage one");
   a_next_stage: assert property (
      (i_ce && rt_expire && !i_trigger && !is_last) |=> st.stage == $past(st.stage) + STG_1)
      else $error("next enabled stage not started");
   a_delay_hold: assert property (
      (st.rt == RT_DELAY && !(i_ce && dly_expire)) |=> st.rt == RT_DELAY)
      else $error("runtime watchdog left delay early");
   a_post_once: assert property (
      (i_ce && i_post_running && st.post_fired) |=> st.post_fired && !o_post_active)
      else $error("boot watchdog rearmed during self test");
   a_off_final: assert property (
      (st.rt == RT_OFF) |=> (st.rt == RT_OFF))
      else $error("disabled runtime watchdog restarted");
   a_stage_range: assert property (
      (st.rt == RT_RUN) |-> (st.stage >= STG_1))
      else $error("runtime stage out of range");

   // Stage actions
   a_act_pulse: assert property (
      (i_ce && (o_pwr_button || o_acpi_overtemp || o_acpi_fatal))
      |=> !(o_pwr_button || o_acpi_overtemp || o_acpi_fatal))
      else $error("action output held beyond one cycle");
   a_stage1_act: assert property (
      (i_ce && rt_expire && !i_trigger && st.stage == STG_1)
      |=> (o_sys_reset == (st.ev1 == ACT_RST)) && (o_pwr_button == (st.ev1 == ACT_PWR)))
      else $error("stage one action mismatch");
   a_stage2_act: assert property (
      (i_ce && rt_expire && !i_trigger && st.stage == STG_2)
      |=> (o_sys_reset == (st.ev2 == ACT_RST)) && (o_pwr_button == (st.ev2 == ACT_PWR))
      && ((o_acpi_overtemp || o_acpi_fatal) == (st.ev2 == ACT_ACPI)))
      else $error("stage two action mismatch");
   a_stage3_act: assert property (
      (i_ce && rt_expire && !i_trigger && st.stage == STG_3)
      |=> (o_sys_reset == (st.ev3 == ACT_RST)) && (o_pwr_button == (st.ev3 == ACT_PWR))
      && ((o_acpi_overtemp || o_acpi_fatal) == (st.ev3 == ACT_ACPI)))
      else $error("stage three action mismatch");

   c_post_reset:  cover property (i_ce && post_expire);
   c_delay_done:  cover property (i_ce && dly_expire);
   c_stage3_fire: cover property (i_ce && rt_expire && st.stage == STG_3);
   c_repeat:      cover property (i_ce && rt_expire && is_last && st.mode == MODE_REPEAT);
   c_once_trig:   cover property (i_ce && st.rt == RT_RUN && st.mode == MODE_ONCE && i_trigger);

endmodule // swd_watchdog

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import swd_pkg::*;
   localparam int TICK = 2;
   logic       i_core_clk, i_arst_n, i_ce, i_stop_user_en, i_stop_pwd_en;
   logic       i_post_running, i_boot_menu_shown, i_pwd_wait, i_acpi_restart;
   logic       i_os_boot_start, i_trigger;
   logic [2:0] i_post_sel, i_rt_delay_sel;
   logic [1:0] i_rt_mode, i_ev1_sel, i_ev2_sel, i_ev3_sel;
   logic [3:0] i_to1_sel, i_to2_sel, i_to3_sel;
   logic       o_sys_reset, o_pwr_button, o_acpi_overtemp, o_acpi_fatal, o_post_active;
   logic [1:0] o_rt_state, o_rt_stage;
   int         err_total, comparisons, cyc, mark;

   swd_watchdog #(.TICK_CYCLES(TICK)) u_swd_watchdog (
      .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_post_sel(i_post_sel),
      .i_stop_user_en(i_stop_user_en), .i_stop_pwd_en(i_stop_pwd_en),
      .i_post_running(i_post_running), .i_boot_menu_shown(i_boot_menu_shown),
      .i_pwd_wait(i_pwd_wait), .i_rt_mode(i_rt_mode), .i_rt_delay_sel(i_rt_delay_sel),
      .i_ev1_sel(i_ev1_sel), .i_ev2_sel(i_ev2_sel), .i_ev3_sel(i_ev3_sel),
      .i_to1_sel(i_to1_sel), .i_to2_sel(i_to2_sel), .i_to3_sel(i_to3_sel),
      .i_acpi_restart(i_acpi_restart), .i_os_boot_start(i_os_boot_start),
      .i_trigger(i_trigger), .o_sys_reset(o_sys_reset), .o_pwr_button(o_pwr_button),
      .o_acpi_overtemp(o_acpi_overtemp), .o_acpi_fatal(o_acpi_fatal),
      .o_post_active(o_post_active), .o_rt_state(o_rt_state), .o_rt_stage(o_rt_stage)
   );

   initial begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end

   always @(posedge i_core_clk) cyc <= cyc + 1;

   function automatic logic [3:0] acts();
      acts = {o_pwr_button, o_acpi_fatal, o_acpi_overtemp, o_sys_reset};
   endfunction

   task automatic final_report();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %0h seen %0h", name, exp, got);
      end
   endtask

   task automatic chk_rng(input string name, input int lo, input int hi, input int got);
      comparisons++;
      if (got < lo || got > hi) begin
         err_total++;
         $display("unexpected %s: expected %0d..%0d seen %0d", name, lo, hi, got);
         if (got > hi) final_report();
      end
   endtask

   task automatic step();
      @(posedge i_core_clk);
      #1;
   endtask

   task automatic pulse(input int which);
      @(posedge i_core_clk);
      if (which == 0) i_os_boot_start <= 1'b1;
      else i_trigger <= 1'b1;
      @(posedge i_core_clk);
      i_os_boot_start <= 1'b0;
      i_trigger <= 1'b0;
   endtask

   // Waits for one action pulse, checks its moment, exclusivity and width
   task automatic wait_out(input int sel, input int len, input int tol, input string name);
      while (((acts() >> sel) & 4'h1) !== 4'h1 && cyc - mark <= len + tol) step();
      chk_rng(name, len - tol, len + tol, cyc - mark);
      chk(name, 4'h1 << sel, acts());
      mark = cyc;
      step();
      chk(name, 4'h0, acts());
   endtask

   task automatic wait_quiet(input int n, input string name);
      int bad;
      bad = 0;
      repeat (n) begin
         step();
         if (acts() !== 4'h0) bad++;
      end
      chk(name, 4'h0, {3'h0, bad != 0});
   endtask

   task automatic start_rt(input logic [1:0] mode, input logic [2:0] dly,
                           input logic [1:0] e1, input logic [1:0] e2, input logic [1:0] e3,
                           input logic [3:0] t1, input logic [3:0] t2, input logic [3:0] t3,
                           input logic rst);
      @(posedge i_core_clk);
      i_arst_n <= 1'b0;
      i_rt_mode <= mode;
      i_rt_delay_sel <= dly;
      i_ev1_sel <= e1;
      i_ev2_sel <= e2;
      i_ev3_sel <= e3;
      i_to1_sel <= t1;
      i_to2_sel <= t2;
      i_to3_sel <= t3;
      i_acpi_restart <= rst;
      repeat (16) @(posedge i_core_clk);
      i_arst_n <= 1'b1;
      repeat (4) step();
      pulse(1);
      wait_quiet(20, "idle trigger");
      chk("idle state", RT_IDLE, o_rt_state);
      pulse(0);
      step();
      mark = cyc;
   endtask

   initial begin
      err_total = 0;
      comparisons = 0;
      cyc = 0;
      mark = 0;
      i_arst_n = 1'b0;
      i_ce = 1'b1;
      i_post_sel = POST_OFF;
      i_stop_user_en = 1'b0;
      i_stop_pwd_en = 1'b1;
      i_post_running = 1'b0;
      i_boot_menu_shown = 1'b0;
      i_pwd_wait = 1'b0;
      i_acpi_restart = 1'b0;
      i_os_boot_start = 1'b0;
      i_trigger = 1'b0;
      i_rt_mode = MODE_OFF;
      i_rt_delay_sel = DLY_OFF;
      {i_ev1_sel, i_ev2_sel, i_ev3_sel} = 6'h00;
      {i_to1_sel, i_to2_sel, i_to3_sel} = 12'h000;
      repeat (16) @(posedge i_core_clk);
      i_arst_n <= 1'b1;
      step();
      chk("reset outputs", 4'h0, acts());
      chk("reset state", 4'h0, {o_rt_state, o_rt_stage});
      // Boot watchdog
      @(posedge i_core_clk);
      i_post_running <= 1'b1;
      repeat (20) step();
      chk("post off", 4'h0, o_post_active);
      @(posedge i_core_clk);
      i_post_running <= 1'b0;
      i_post_sel <= 3'h1;
      repeat (20) step();
      chk("post idle", 4'h0, o_post_active);
      @(posedge i_core_clk);
      i_post_running <= 1'b1;
      i_boot_menu_shown <= 1'b1;
      step();
      mark = cyc;
      repeat (50) step();
      chk("menu no halt", 4'h1, o_post_active);
      @(posedge i_core_clk);
      i_stop_user_en <= 1'b1;
      repeat (200) step();
      chk("menu halt", 4'h0, o_post_active);
      @(posedge i_core_clk);
      i_boot_menu_shown <= 1'b0;
      i_pwd_wait <= 1'b1;
      repeat (200) step();
      chk("pwd halt", 4'h0, o_post_active);
      @(posedge i_core_clk);
      i_pwd_wait <= 1'b0;
      repeat (3) step();
      chk("post count", 4'h1, o_post_active);
      wait_out(0, 30000 * TICK + 400, 8, "boot reset");
      wait_quiet(200, "boot once");
      @(posedge i_core_clk);
      i_post_running <= 1'b0;
      // Runtime: disabled mode
      start_rt(MODE_OFF, DLY_OFF, ACT_RST, ACT_NONE, ACT_NONE, 4'h0, 4'h0, 4'h0, 1'b0);
      chk("off mode", RT_OFF, o_rt_state);
      // Single event, three stages
      start_rt(MODE_SINGLE, DLY_OFF, ACT_RST, ACT_ACPI, ACT_PWR, 4'h0, 4'h1, 4'h0, 1'b0);
      chk("single run", {RT_RUN, STG_1}, {o_rt_state, o_rt_stage});
      wait_out(0, 1000 * TICK, 6, "stage1 reset");
      chk("stage two", STG_2, o_rt_stage);
      wait_out(1, 2000 * TICK, 6, "stage2 shutdown");
      chk("stage three", STG_3, o_rt_stage);
      wait_out(3, 1000 * TICK, 6, "stage3 power");
      chk("single end", RT_OFF, o_rt_state);
      wait_quiet(2100, "single quiet");
      // Repeated event, stage one last, trigger reload
      start_rt(MODE_REPEAT, DLY_OFF, ACT_NONE, ACT_NONE, ACT_PWR, 4'h0, 4'h0, 4'h0, 1'b1);
      repeat (500 * TICK) step();
      pulse(1);
      mark = cyc;
      wait_out(2, 1000 * TICK, 6, "reload restart");
      chk("repeat stage", {RT_RUN, STG_1}, {o_rt_state, o_rt_stage});
      wait_out(2, 1000 * TICK, 6, "repeat restart");
      chk("repeat run", {RT_RUN, STG_1}, {o_rt_state, o_rt_stage});
      // One-time trigger with activation delay
      start_rt(MODE_ONCE, 3'h1, ACT_RST, ACT_NONE, ACT_NONE, 4'h0, 4'h0, 4'h0, 1'b0);
      chk("delay state", RT_DELAY, o_rt_state);
      repeat (100) step();
      pulse(1);
      step();
      chk("delay trigger", RT_DELAY, o_rt_state);
      // Enable low for 101 edges stretches the delay by as much
      @(posedge i_core_clk);
      i_ce <= 1'b0;
      repeat (100) step();
      chk("ce freeze", {RT_DELAY, STG_1}, {o_rt_state, o_rt_stage});
      @(posedge i_core_clk);
      i_ce <= 1'b1;
      while (o_rt_state !== RT_RUN && cyc - mark <= 10000 * TICK + 107) step();
      chk_rng("delay length", 10000 * TICK + 95, 10000 * TICK + 107, cyc - mark);
      repeat (20) step();
      pulse(1);
      step();
      chk("once end", RT_OFF, o_rt_state);
      wait_quiet(1000 * TICK + 100, "once quiet");
      final_report();
   end
endmodule // tb_top
